/* design/mss_top.sv */
// motor stop sequencing and start-input interpretation with terminal function registers
//
// Notes on behaviour
// - setting 0..100: two start inputs; output off that many seconds after release
// - setting 1000..1100: start plus direction; output off (setting-1000) s after release
// - setting 9999 (reset value): two start inputs; release decelerates along the ramp
// - setting 8888: start plus direction; release decelerates along the ramp
// - output-active flag drops exactly when output is shut off, any stop path
// - power-fail, panel, comm-error stop or jog make the stop setting ignored
// - during a delayed stop the ramp keeps following the command until shutoff
// - start during coasting restarts from the starting frequency
// - stop and terminal settings writable only while extended access equals zero
// - five terminal function codes, defaults 60, 61, 0, 1, 2
// - code 61 only on forward/reverse terminals; speed terminals take common set
// - speed terminals default to low, middle, high speed commands
// - one code on several terminals: any of them asserts the function
`timescale 1ns/1ps
module mss_top #(
   parameter int unsigned CYC_PER_SEC = mss_pkg::MSS_TICK_CYC
) (
   // clock and reset
   input  wire logic                      i_clk,
   input  wire logic                      i_rst_n,
   // register port
   input  wire logic [3:0]                i_addr,
   input  wire logic [mss_pkg::MSS_DW-1:0] i_wdata,
   input  wire logic                      i_wr,
   input  wire logic                      i_rd,
   output logic [mss_pkg::MSS_DW-1:0]     o_rdata,
   // contact inputs: fwd, rev, low, mid, high
   input  wire logic [mss_pkg::MSS_NTERM-1:0] i_term,
   // override conditions
   input  wire logic                      i_pwr_fail_stop,
   input  wire logic                      i_panel_stop,
   input  wire logic                      i_comm_err_stop,
   input  wire logic                      i_jog_mode,
   // ramp and motor feedback
   input  wire logic                      i_ramp_zero,
   input  wire logic                      i_motor_stopped,
   // drive control
   output logic                           o_out_on,
   output logic                           o_ramp_run,
   output logic                           o_ramp_decel,
   output logic                           o_dir_rev,
   output logic                           o_start_fmin,
   output logic [2:0]                     o_speed_sel
);
   import mss_pkg::*;

   typedef struct packed {
      logic [15:0]        stop;
      logic [4:0][15:0]   fn;
      logic [15:0]        ext;
      logic [15:0]        rdata;
      mss_state_e         st;
      logic               on;
      logic               ramp;
      logic               decel;
      logic               rev;
      logic               fmin;
      logic               tload;
      logic [2:0]         spd;
   } mss_top_s;

   localparam mss_top_s MSS_RST = '{
      stop:  MSS_RST_STOP,
      fn:    {MSS_RST_HIGH, MSS_RST_MID, MSS_RST_LOW, MSS_RST_REV, MSS_RST_FWD},
      ext:   MSS_RST_EXT,
      rdata: 16'h0000,
      st:    MSS_IDLE,
      on:    1'b0,
      ramp:  1'b0,
      decel: 1'b0,
      rev:   1'b0,
      fmin:  1'b0,
      tload: 1'b0,
      spd:   3'h0
   };

   mss_top_s    r;
   mss_top_s    next_r;

   logic        fwd_f;
   logic        rev_f;
   logic        low_f;
   logic        mid_f;
   logic        high_f;
   logic        dirmode;
   logic        dlymode;
   logic        ovr;
   logic        delayed;
   logic        start_req;
   logic        want_rev;
   logic        unlocked;
   logic [6:0]  secs;
   logic        tmr_done;
   logic [15:0] stat;

   mss_term_map #(
      .N      (MSS_NTERM)
   ) u_map (
      .i_term (i_term),
      .i_code (r.fn),
      .o_fwd  (fwd_f),
      .o_rev  (rev_f),
      .o_low  (low_f),
      .o_mid  (mid_f),
      .o_high (high_f)
   );

   // timer is held clear outside the delay state so a stale expiry cannot leak
   mss_sec_timer #(
      .CYC_PER_SEC (CYC_PER_SEC)
   ) u_tmr (
      .i_clk       (i_clk),
      .i_rst_n     (i_rst_n),
      .i_load      (r.tload),
      .i_clear     (r.st != MSS_DLY),
      .i_secs      (secs),
      .o_done      (tmr_done)
   );

   // stop-setting decode
   assign dirmode = ((r.stop >= MSS_SM_DIR_MIN) && (r.stop <= MSS_SM_DIR_MAX)) ||
                    (r.stop == MSS_SM_DIR_DECEL);
   assign dlymode = (r.stop <= MSS_SM_DLY_MAX) ||
                    ((r.stop >= MSS_SM_DIR_MIN) && (r.stop <= MSS_SM_DIR_MAX));
   assign ovr     = i_pwr_fail_stop | i_panel_stop | i_comm_err_stop | i_jog_mode;
   assign delayed = dlymode && !ovr;
   assign secs    = (r.stop <= MSS_SM_DLY_MAX) ? r.stop[6:0] : 7'(r.stop - MSS_SM_DIR_MIN);

   // both start inputs on in two-input mode means no valid command, so stop
   assign start_req = dirmode ? fwd_f : (fwd_f ^ rev_f);
   assign want_rev  = dirmode ? rev_f : (rev_f && !fwd_f);
   assign unlocked  = (r.ext == 16'h0000);

   always_comb begin
      stat = 16'h0000;
      stat[MSS_ST_ON]    = r.on;
      stat[MSS_ST_DIR]   = r.rev;
      stat[MSS_ST_DLY]   = (r.st == MSS_DLY);
      stat[MSS_ST_COAST] = (r.st == MSS_COAST);
      stat[MSS_ST_DECEL] = r.decel;
   end

   always_comb begin
      next_r = r;
      next_r.fmin  = 1'b0;
      next_r.tload = 1'b0;
      next_r.spd   = {high_f, mid_f, low_f};

      // register writes; illegal values are dropped, not clipped
      if (i_wr) begin
         if (i_addr == MSS_A_EXT) begin
            next_r.ext = i_wdata;
         end
         if (i_addr == MSS_A_STOP && unlocked && mss_stop_ok(i_wdata)) begin
            next_r.stop = i_wdata;
         end
         for (int k = 0; k < MSS_NTERM; k++) begin
            if (i_addr == MSS_A_FWD + 4'(k) && unlocked && mss_code_ok(i_wdata, k)) begin
               next_r.fn[k] = i_wdata;
            end
         end
      end

      // read data stands only in the cycle after the strobe
      next_r.rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            MSS_A_STOP: begin
               next_r.rdata = r.stop;
            end
            MSS_A_FWD, MSS_A_REV, MSS_A_LOW, MSS_A_MID, MSS_A_HIGH: begin
               next_r.rdata = r.fn[3'(i_addr - MSS_A_FWD)];
            end
            MSS_A_EXT: begin
               next_r.rdata = r.ext;
            end
            MSS_A_STAT: begin
               next_r.rdata = stat;
            end
            default: begin
               next_r.rdata = 16'h0000;
            end
         endcase
      end

      case (r.st)
         MSS_IDLE, MSS_COAST: begin
            if (start_req) begin
               next_r.st    = MSS_RUN;
               next_r.on    = 1'b1;
               next_r.ramp  = 1'b1;
               next_r.decel = 1'b0;
               next_r.rev   = want_rev;
               next_r.fmin  = (r.st == MSS_COAST);
            end else if (r.st == MSS_COAST && i_motor_stopped) begin
               next_r.st = MSS_IDLE;
            end
         end
         MSS_RUN: begin
            if (start_req) begin
               next_r.rev = want_rev;
            end else if (delayed) begin
               next_r.st    = MSS_DLY;
               next_r.tload = 1'b1;
            end else begin
               next_r.st    = MSS_DECEL;
               next_r.ramp  = 1'b0;
               next_r.decel = 1'b1;
            end
         end
         MSS_DLY: begin
            if (start_req) begin
               next_r.st  = MSS_RUN;
               next_r.rev = want_rev;
            end else if (ovr) begin
               next_r.st    = MSS_DECEL;
               next_r.ramp  = 1'b0;
               next_r.decel = 1'b1;
            end else if (tmr_done) begin
               next_r.st   = MSS_COAST;
               next_r.on   = 1'b0;
               next_r.ramp = 1'b0;
            end
         end
         MSS_DECEL: begin
            if (start_req) begin
               next_r.st    = MSS_RUN;
               next_r.ramp  = 1'b1;
               next_r.decel = 1'b0;
               next_r.rev   = want_rev;
            end else if (i_ramp_zero) begin
               next_r.st    = MSS_IDLE;
               next_r.on    = 1'b0;
               next_r.decel = 1'b0;
            end
         end
         default: begin
            next_r = MSS_RST;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= MSS_RST;
      end else begin
         r <= next_r;
      end
   end

   assign o_rdata      = r.rdata;
   assign o_out_on     = r.on;
   assign o_ramp_run   = r.ramp;
   assign o_ramp_decel = r.decel;
   assign o_dir_rev    = r.rev;
   assign o_start_fmin = r.fmin;
   assign o_speed_sel  = r.spd;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   shutoff_flag_a: assert property (
      (r.st == MSS_DLY && !start_req && !ovr && tmr_done) |=> !o_out_on && !o_ramp_run && r.st == MSS_COAST)
      else $error("output-active flag not dropped at delayed shutoff");

   decel_path_a: assert property (
      (r.st == MSS_RUN && !start_req && !delayed) |=> o_ramp_decel && o_out_on ##1 (o_out_on || $past(i_ramp_zero)))
      else $error("release without delay did not decelerate");

   delay_ramp_a: assert property (
      (r.st == MSS_RUN && !start_req && delayed) |=> (r.st == MSS_DLY && o_ramp_run && o_out_on && !o_ramp_decel))
      else $error("ramp did not keep running in delayed stop");

   override_wins_a: assert property (
      (ovr && r.st == MSS_RUN && !start_req) |=> r.st == MSS_DECEL)
      else $error("stop setting honoured while override active");

   coast_restart_a: assert property (
      (r.st == MSS_COAST && start_req) |=> o_start_fmin && o_out_on ##1 !o_start_fmin)
      else $error("coast restart did not request starting frequency");

   write_lock_a: assert property (
      (i_wr && i_addr == MSS_A_STOP && r.ext != 16'h0000) |=> $stable(r.stop))
      else $error("stop setting written while locked");

   rev_code_a: assert property (
      (i_wr && i_addr == MSS_A_LOW && i_wdata == MSS_FN_REV) |=> $stable(r.fn[2]))
      else $error("reverse code accepted on a speed terminal");

   early_start_a: assert property (
      (r.st == MSS_DLY && start_req) |=> r.st == MSS_RUN ##1 !tmr_done)
      else $error("delay not cleared by early restart");

   dir_select_a: assert property (
      (r.st == MSS_IDLE && start_req && dirmode) |=> o_dir_rev == $past(rev_f))
      else $error("direction input not honoured in start-direction mode");

   read_slot_a: assert property (
      (i_rd && i_addr == MSS_A_STOP) |=> o_rdata == $past(r.stop) ##1 ($past(i_rd) || o_rdata == 16'h0000))
      else $error("read data not in the slot after the strobe");

   // speed checks watch one terminal alone so a broken decoder cannot hide behind the others
   low_map_a: assert property (
      (r.fn[2] == MSS_FN_LOW && i_term[2]) |=> o_speed_sel[0])
      else $error("low speed terminal did not select low speed");

   high_share_a: assert property (
      (r.fn[2] == MSS_FN_HIGH && i_term[2]) |=> o_speed_sel[2])
      else $error("shared high speed code not honoured on low speed terminal");

   term_lock_a: assert property (
      (i_wr && i_addr >= MSS_A_FWD && i_addr <= MSS_A_HIGH && r.ext != 16'h0000) |=> $stable(r.fn))
      else $error("terminal function written while locked");

   idle_start_a: assert property (
      (r.st == MSS_IDLE && start_req) |=> o_out_on && o_ramp_run && !o_start_fmin)
      else $error("start from standstill not a plain start");

   two_input_dir_a: assert property (
      (r.st == MSS_IDLE && start_req && !dirmode) |=> o_dir_rev == $past(rev_f))
      else $error("direction wrong in two-input start mode");

   hold_delay_a: assert property (
      (r.st == MSS_DLY && !start_req && !ovr && !tmr_done) |=> r.st == MSS_DLY && o_out_on && o_ramp_run)
      else $error("delayed stop left early");

   dly_abort_a: assert property (
      (r.st == MSS_DLY && !start_req && ovr) |=> r.st == MSS_DECEL && o_ramp_decel && o_out_on)
      else $error("override did not turn a running delay into a ramp stop");

   ramp_stop_a: assert property (
      (r.st == MSS_DECEL && !start_req && i_ramp_zero) |=> !o_out_on && !o_ramp_decel && r.st == MSS_IDLE)
      else $error("output-active flag not dropped at end of ramp stop");

   delay_cov_c: cover property (r.st == MSS_DLY ##1 r.st == MSS_COAST);
   decel_cov_c: cover property (r.st == MSS_DECEL && i_ramp_zero);
   restart_cov_c: cover property (r.st == MSS_COAST && start_req);
   abort_cov_c: cover property (r.st == MSS_DLY && ovr);
   dirmode_cov_c: cover property (r.st == MSS_RUN && dirmode && o_dir_rev);
endmodule

/* design/mss_pkg.sv */
// package: register map, function codes, timing and state types of the stop and input-select block
package mss_pkg;
   localparam int MSS_DW    = 16;
   localparam int MSS_NTERM = 5;

   // register word addresses
   localparam logic [3:0] MSS_A_STOP = 4'h0;
   localparam logic [3:0] MSS_A_FWD  = 4'h1;
   localparam logic [3:0] MSS_A_REV  = 4'h2;
   localparam logic [3:0] MSS_A_LOW  = 4'h3;
   localparam logic [3:0] MSS_A_MID  = 4'h4;
   localparam logic [3:0] MSS_A_HIGH = 4'h5;
   localparam logic [3:0] MSS_A_EXT  = 4'h6;
   localparam logic [3:0] MSS_A_STAT = 4'h7;

   // reset values
   localparam logic [15:0] MSS_RST_STOP = 16'h270f;
   localparam logic [15:0] MSS_RST_FWD  = 16'h003c;
   localparam logic [15:0] MSS_RST_REV  = 16'h003d;
   localparam logic [15:0] MSS_RST_LOW  = 16'h0000;
   localparam logic [15:0] MSS_RST_MID  = 16'h0001;
   localparam logic [15:0] MSS_RST_HIGH = 16'h0002;
   localparam logic [15:0] MSS_RST_EXT  = 16'h0000;

   // terminal function codes
   localparam logic [15:0] MSS_FN_LOW  = 16'h0000;
   localparam logic [15:0] MSS_FN_MID  = 16'h0001;
   localparam logic [15:0] MSS_FN_HIGH = 16'h0002;
   localparam logic [15:0] MSS_FN_FWD  = 16'h003c;
   localparam logic [15:0] MSS_FN_REV  = 16'h003d;
   localparam logic [15:0] MSS_FN_NONE = 16'h270f;

   // stop-mode setting ranges
   localparam logic [15:0] MSS_SM_DLY_MAX   = 16'h0064;
   localparam logic [15:0] MSS_SM_DIR_MIN   = 16'h03e8;
   localparam logic [15:0] MSS_SM_DIR_MAX   = 16'h044c;
   localparam logic [15:0] MSS_SM_DECEL     = 16'h270f;
   localparam logic [15:0] MSS_SM_DIR_DECEL = 16'h22b8;

   // timing: one shutoff-delay unit is one second
   localparam int MSS_CLK_HZ   = 200_000_000;
   localparam int MSS_TICK_S   = 1;
   localparam int MSS_TICK_CYC = MSS_CLK_HZ * MSS_TICK_S;

   // status register bit positions
   localparam int MSS_ST_ON    = 0;
   localparam int MSS_ST_DIR   = 1;
   localparam int MSS_ST_DLY   = 2;
   localparam int MSS_ST_COAST = 3;
   localparam int MSS_ST_DECEL = 4;

   typedef enum logic [2:0] {MSS_IDLE, MSS_RUN, MSS_DLY, MSS_DECEL, MSS_COAST} mss_state_e;

   function automatic logic mss_stop_ok(input logic [15:0] v);
      return (v <= MSS_SM_DLY_MAX) || (v >= MSS_SM_DIR_MIN && v <= MSS_SM_DIR_MAX) ||
             (v == MSS_SM_DECEL) || (v == MSS_SM_DIR_DECEL);
   endfunction

   // idx 0 is the forward terminal, idx 1 the reverse terminal
   function automatic logic mss_code_ok(input logic [15:0] c, input int idx);
      logic ok;
      case (c)
         16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007, 16'h0008,
         16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0018, 16'h0019, 16'h0025,
         16'h003e, 16'h0041, 16'h0042, 16'h0043, MSS_FN_NONE: ok = 1'b1;
         MSS_FN_REV: ok = (idx <= 1);
         MSS_FN_FWD: ok = (idx == 0);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction
endpackage

/* design/mss_term_map.sv */
// terminal-to-function decoder: ors every terminal that carries a given function code
`timescale 1ns/1ps
module mss_term_map #(
   parameter int N = 5
) (
   // terminals and their codes
   input  wire logic [N-1:0]       i_term,
   input  wire logic [N-1:0][15:0] i_code,
   // decoded functions
   output logic                    o_fwd,
   output logic                    o_rev,
   output logic                    o_low,
   output logic                    o_mid,
   output logic                    o_high
);
   import mss_pkg::*;

   logic [N-1:0] hit_fwd;
   logic [N-1:0] hit_rev;
   logic [N-1:0] hit_low;
   logic [N-1:0] hit_mid;
   logic [N-1:0] hit_high;

   for (genvar g = 0; g < N; g++) begin : g_term
      assign hit_fwd[g]  = i_term[g] && (i_code[g] == MSS_FN_FWD);
      assign hit_rev[g]  = i_term[g] && (i_code[g] == MSS_FN_REV);
      assign hit_low[g]  = i_term[g] && (i_code[g] == MSS_FN_LOW);
      assign hit_mid[g]  = i_term[g] && (i_code[g] == MSS_FN_MID);
      assign hit_high[g] = i_term[g] && (i_code[g] == MSS_FN_HIGH);
   end

   // shared codes simply or together
   assign o_fwd  = |hit_fwd;
   assign o_rev  = |hit_rev;
   assign o_low  = |hit_low;
   assign o_mid  = |hit_mid;
   assign o_high = |hit_high;
endmodule

/* design/mss_sec_timer.sv */
// shutoff delay timer: whole seconds counted with a one-second enable divider
`timescale 1ns/1ps
module mss_sec_timer #(
   parameter int unsigned CYC_PER_SEC = mss_pkg::MSS_TICK_CYC
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // control
   input  wire logic       i_load,
   input  wire logic       i_clear,
   input  wire logic [6:0] i_secs,
   // expiry pulse
   output logic            o_done
);
   import mss_pkg::*;

   typedef struct packed {
      logic        busy;
      logic [6:0]  secs;
      logic [31:0] div;
      logic        done;
   } mss_tmr_s;

   mss_tmr_s r;
   mss_tmr_s next_r;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (i_clear) begin
         next_r.busy = 1'b0;
      end else if (i_load) begin
         // every load restarts the whole delay
         next_r.busy = 1'b1;
         next_r.secs = i_secs;
         next_r.div  = 32'h0000_0000;
      end else if (r.busy) begin
         if (r.secs == 7'h00) begin
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
         end else if (r.div == 32'(CYC_PER_SEC - 1)) begin
            next_r.div  = 32'h0000_0000;
            next_r.secs = r.secs - 7'h01;
         end else begin
            next_r.div = r.div + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_done = r.done;
endmodule

/* verification/mss_contact_model.sv */
// far-side model: contact switches plus ramp and motor feedback
`timescale 1ns/1ps
module mss_contact_model #(
   parameter int RAMP_CYC  = 8,
   parameter int COAST_CYC = 40
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // switch positions requested by the bench
   input  wire logic [4:0] i_cmd,
   // drive state seen by the model
   input  wire logic       i_ramp_decel,
   input  wire logic       i_out_on,
   // contacts and feedback toward the block
   output logic [4:0]      o_term,
   output logic            o_ramp_zero,
   output logic            o_motor_stopped
);
   int dcnt;
   int ccnt;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_term          <= 5'h00;
         dcnt            <= 0;
         ccnt            <= 0;
         o_ramp_zero     <= 1'b0;
         o_motor_stopped <= 1'b0;
      end else begin
         // contacts settle one cycle after the switch is thrown
         o_term      <= i_cmd;
         dcnt        <= i_ramp_decel ? dcnt + 1 : 0;
         o_ramp_zero <= i_ramp_decel && (dcnt >= RAMP_CYC);
         // a coasting motor needs a while to spin down, so restarts can land mid-coast
         ccnt            <= i_out_on ? 0 : ccnt + 1;
         o_motor_stopped <= !i_out_on && (ccnt >= COAST_CYC);
      end
   end
endmodule

/* verification/tb_motor_stop_and_input_select.sv */
// self-checking bench for the stop and input-select block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t ns: got %h expected %h", $time, a, b); end end
module tb_motor_stop_and_input_select;
   import mss_pkg::*;
   // short second keeps delayed stops within a few dozen cycles
   localparam int CPS = 10;
   logic        i_clk;
   logic        i_rst_n;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [15:0] o_rdata;
   logic [4:0]  cmd;
   logic [4:0]  term;
   logic [3:0]  ovr;
   logic        ramp_zero;
   logic        motor_stopped;
   logic        o_out_on;
   logic        o_ramp_run;
   logic        o_ramp_decel;
   logic        o_dir_rev;
   logic        o_start_fmin;
   logic [2:0]  o_speed_sel;
   int          fail_count;
   int          samples_checked;

   mss_top #(.CYC_PER_SEC(CPS)) uut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_term(term), .i_pwr_fail_stop(ovr[0]), .i_panel_stop(ovr[1]),
      .i_comm_err_stop(ovr[2]), .i_jog_mode(ovr[3]), .i_ramp_zero(ramp_zero),
      .i_motor_stopped(motor_stopped), .o_out_on(o_out_on), .o_ramp_run(o_ramp_run),
      .o_ramp_decel(o_ramp_decel), .o_dir_rev(o_dir_rev), .o_start_fmin(o_start_fmin),
      .o_speed_sel(o_speed_sel)
   );

   mss_contact_model partner (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_ramp_decel(o_ramp_decel), .i_out_on(o_out_on),
      .o_term(term), .o_ramp_zero(ramp_zero), .o_motor_stopped(motor_stopped)
   );

   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic drive(input logic [4:0] c);
      @(posedge i_clk);
      cmd <= c;
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1;
      `CHK(o_rdata, e)
   endtask

   // bounded wait for the run indication to reach a level
   task automatic wait_out(input logic v, input int lim);
      int n;
      n = 0;
      while (o_out_on !== v && n < lim) begin
         cyc(1);
         n++;
      end
      `CHK(o_out_on, v)
      if (o_out_on !== v) complete_run();
   endtask

   task automatic t_regs();
      logic [15:0] rv [7];
      rv = '{MSS_RST_STOP, MSS_RST_FWD, MSS_RST_REV, MSS_RST_LOW, MSS_RST_MID, MSS_RST_HIGH, MSS_RST_EXT};
      for (int a = 0; a < 7; a++) rd(a[3:0], rv[a]);
      rd(4'h8, 16'h0000);
      $display("test reset registers done");
   endtask

   task automatic t_decel();
      drive(5'b00011);
      cyc(5); `CHK(o_out_on, 1'b0)
      drive(5'b00010);
      cyc(4); `CHK(o_out_on, 1'b1)
      `CHK(o_dir_rev, 1'b1)
      rd(MSS_A_STAT, 16'h0003);
      drive(5'b00000);
      cyc(4); `CHK(o_ramp_decel, 1'b1)
      `CHK(o_out_on, 1'b1)
      wait_out(1'b0, 20);
      $display("test ramp stop done");
   endtask

   task automatic t_delay();
      logic seen;
      seen = 1'b0;
      wr(MSS_A_STOP, 16'h0002);
      drive(5'b00001);
      cyc(4); `CHK(o_out_on, 1'b1)
      drive(5'b00000);
      cyc(15); `CHK(o_out_on, 1'b1)
      `CHK(o_ramp_run, 1'b1)
      `CHK(o_ramp_decel, 1'b0)
      rd(MSS_A_STAT, 16'h0005);
      wait_out(1'b0, 15);
      `CHK(o_ramp_run, 1'b0)
      drive(5'b00001);
      for (int i = 0; i < 5; i++) begin
         cyc(1);
         seen = seen | o_start_fmin;
      end
      `CHK(seen, 1'b1)
      drive(5'b00000);
      wait_out(1'b0, 40);
      cyc(50);
      $display("test delayed coast done");
   endtask

   task automatic t_dirmode();
      wr(MSS_A_STOP, MSS_SM_DIR_DECEL);
      drive(5'b00011);
      cyc(4); `CHK(o_out_on, 1'b1)
      `CHK(o_dir_rev, 1'b1)
      drive(5'b00010);
      cyc(4); `CHK(o_ramp_decel, 1'b1)
      wait_out(1'b0, 20);
      wr(MSS_A_STOP, 16'h03e9);
      drive(5'b00001);
      cyc(4); `CHK(o_dir_rev, 1'b0)
      drive(5'b00000);
      cyc(8); `CHK(o_out_on, 1'b1)
      wait_out(1'b0, 10);
      cyc(50);
      $display("test direction modes done");
   endtask

   task automatic t_override();
      wr(MSS_A_STOP, 16'h0005);
      for (int i = 0; i < 4; i++) begin
         drive(5'b00001);
         cyc(4);
         @(posedge i_clk);
         ovr <= 4'b0001 << i;
         cmd <= 5'b00000;
         cyc(4); `CHK(o_ramp_decel, 1'b1)
         wait_out(1'b0, 20);
         @(posedge i_clk);
         ovr <= 4'b0000;
         cyc(3);
      end
      // override arriving while a delayed stop is already running
      drive(5'b00001);
      cyc(4);
      drive(5'b00000);
      cyc(6); `CHK(o_ramp_run, 1'b1)
      @(posedge i_clk);
      ovr <= 4'b0100;
      cyc(3); `CHK(o_ramp_decel, 1'b1)
      wait_out(1'b0, 20);
      @(posedge i_clk);
      ovr <= 4'b0000;
      $display("test stop overrides done");
   endtask

   task automatic t_restart_delay();
      wr(MSS_A_STOP, 16'h0003);
      drive(5'b00001);
      cyc(4);
      drive(5'b00000);
      cyc(20);
      drive(5'b00001);
      cyc(5); `CHK(o_out_on, 1'b1)
      drive(5'b00000);
      cyc(25); `CHK(o_out_on, 1'b1)
      wait_out(1'b0, 20);
      cyc(50);
      $display("test delay restart done");
   endtask

   task automatic t_access();
      wr(MSS_A_EXT, 16'h0001);
      wr(MSS_A_STOP, 16'h0000);
      rd(MSS_A_STOP, 16'h0003);
      wr(MSS_A_LOW, MSS_FN_HIGH);
      rd(MSS_A_LOW, MSS_RST_LOW);
      wr(MSS_A_EXT, 16'h0000);
      wr(MSS_A_STOP, 16'h0000);
      rd(MSS_A_STOP, 16'h0000);
      wr(MSS_A_MID, MSS_FN_REV);
      rd(MSS_A_MID, MSS_RST_MID);
      wr(MSS_A_LOW, MSS_FN_REV);
      rd(MSS_A_LOW, MSS_RST_LOW);
      wr(MSS_A_REV, MSS_FN_NONE);
      rd(MSS_A_REV, MSS_FN_NONE);
      wr(MSS_A_REV, MSS_FN_REV);
      rd(MSS_A_REV, MSS_FN_REV);
      for (int i = 0; i < 3; i++) begin
         drive(5'b00100 << i);
         cyc(3); `CHK(o_speed_sel, 3'b001 << i)
      end
      wr(MSS_A_LOW, MSS_FN_HIGH);
      drive(5'b00100);
      cyc(3); `CHK(o_speed_sel, 3'b100)
      drive(5'b10100);
      cyc(3); `CHK(o_speed_sel, 3'b100)
      drive(5'b00000);
      $display("test register access done");
   endtask

   initial begin
      i_rst_n = 1'b0;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      cmd = 5'h00;
      ovr = 4'h0;
      fail_count = 0;
      samples_checked = 0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_regs();
      t_decel();
      t_delay();
      t_dirmode();
      t_override();
      t_restart_delay();
      t_access();
      complete_run();
   end
endmodule
